//--- link_fmt_pkg.sv
package link_fmt_pkg;

  // ****************************************************
  // quadlet layout
  // ****************************************************
  localparam int          QUAD_W        = 32;
  localparam int          TCODE_LSB     = 4;
  localparam int          TCODE_W       = 4;
  localparam logic [3:0]  TCODE_PHYCFG  = 4'he;
  localparam logic [3:0]  TCODE_PHYOUT  = 4'h0;

  // ****************************************************
  // self-id framing
  // ****************************************************
  localparam logic [31:0] SELFID_HEADER = 32'h0000_00e0;
  localparam logic [31:0] ACK_QUAD_BASE = 32'h0000_8000;
  localparam int          ACK_W         = 4;
  localparam logic [3:0]  ACK_COMPLETE  = 4'h1;
  localparam logic [3:0]  ACK_DATA_ERR  = 4'hd;
  // 63 nodes with up to four packets each
  localparam int          SID_DEPTH     = 256;
  localparam int          SID_AW        = 8;
  localparam logic [7:0]  SID_LAST      = 8'hff;
  localparam logic [7:0]  SID_ONE       = 8'h01;

  // ****************************************************
  // cycle mark
  // ****************************************************
  // position of the cycle-done bit inside the marker quadlet
  localparam int          CYDONE_BIT    = 0;
  localparam logic [31:0] CYMARK_BASE   = 32'h0000_0000;

endpackage

//--- phycfg_retag.sv
`timescale 1ns/10ps
module phycfg_retag
  import link_fmt_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_sync_n,
  input  wire logic              host_tx_valid,
  input  wire logic              host_tx_first,
  input  wire logic [QUAD_W-1:0] host_tx_data,
  output wire logic              host_tx_ready,
  output logic                   phy_tx_valid,
  output logic                   phy_tx_first,
  output logic [QUAD_W-1:0]      phy_tx_data,
  input  wire logic              phy_tx_ready
);

  wire logic              is_cfg;
  logic      [QUAD_W-1:0] retagged;
  wire logic              take;

  // a one-stage slice: the host stalls only while a held quadlet waits on a phy stall
  assign host_tx_ready = !phy_tx_valid || phy_tx_ready;
  assign take          = host_tx_valid && host_tx_ready;
  assign is_cfg        = host_tx_first &&
                         (host_tx_data[TCODE_LSB +: TCODE_W] == TCODE_PHYCFG);

  always_comb begin
    retagged = host_tx_data;
    if (is_cfg) begin
      retagged[TCODE_LSB +: TCODE_W] = TCODE_PHYOUT;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      phy_tx_valid <= 1'b0;
      phy_tx_first <= 1'b0;
      phy_tx_data  <= '0;
    end else if (take) begin
      phy_tx_valid <= 1'b1;
      phy_tx_first <= host_tx_first;
      phy_tx_data  <= retagged;
    end else if (phy_tx_ready) begin
      phy_tx_valid <= 1'b0;
    end
  end

endmodule // phycfg_retag

//--- link_rx_special_packet_format.sv
`timescale 1ns/10ps
// What this block does
// - one cycle-done marker per isochronous cycle end
// - config tcode Eh becomes 0h toward phy
// - route select picks broadcast or bulk fifo
// - ack 0001b clean, 1101b on error
// - lone node gives ack plus header only in bulk fifo, header alone in broadcast fifo
// - no ack quadlet in broadcast fifo
// - header ahead of the quadlets, each quadlet then its inverse
// - bulk fifo gets ack quadlet before header
module link_rx_special_packet_format
  import link_fmt_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // isochronous receiver
  input  wire logic              iso_cycle_end,
  output logic                   cymark_wr,
  output logic [QUAD_W-1:0]      cymark_data,
  // self-id receiver
  input  wire logic              selfid_route_select,
  input  wire logic              selfid_start,
  input  wire logic              selfid_quad_valid,
  input  wire logic [QUAD_W-1:0] selfid_quad,
  input  wire logic              selfid_end,
  input  wire logic              selfid_error,
  output wire logic              selfid_busy,
  output logic                   broadcast_write_rx_fifo_wr,
  output logic [QUAD_W-1:0]      broadcast_write_rx_fifo_data,
  output logic                   bulk_async_rx_fifo_wr,
  output logic [QUAD_W-1:0]      bulk_async_rx_fifo_data,
  // transmit path
  input  wire logic              host_tx_valid,
  input  wire logic              host_tx_first,
  input  wire logic [QUAD_W-1:0] host_tx_data,
  output wire logic              host_tx_ready,
  output wire logic              phy_tx_valid,
  output wire logic              phy_tx_first,
  output wire logic [QUAD_W-1:0] phy_tx_data,
  input  wire logic              phy_tx_ready
);

  // ****************************************************
  // reset release
  // ****************************************************
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************************
  // cycle mark
  // ****************************************************
  wire logic [QUAD_W-1:0] cymark_quad;

  assign cymark_quad = CYMARK_BASE | (QUAD_W'(1) << CYDONE_BIT);

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      cymark_wr   <= 1'b0;
      cymark_data <= '0;
    end else begin
      cymark_wr   <= iso_cycle_end;
      cymark_data <= cymark_quad;
    end
  end

  // ****************************************************
  // transmit retag
  // ****************************************************
  phycfg_retag u_retag (
    .clk_sys       (clk_sys),
    .rst_sync_n    (rst_sync_q),
    .host_tx_valid (host_tx_valid),
    .host_tx_first (host_tx_first),
    .host_tx_data  (host_tx_data),
    .host_tx_ready (host_tx_ready),
    .phy_tx_valid  (phy_tx_valid),
    .phy_tx_first  (phy_tx_first),
    .phy_tx_data   (phy_tx_data),
    .phy_tx_ready  (phy_tx_ready)
  );

  // ****************************************************
  // self-id collection
  // ****************************************************
  // the ack is only known at the end of the phase but goes first in the
  // bulk fifo, so the quadlets are held until then
  typedef enum logic [2:0] {
    SID_IDLE,
    SID_COLLECT,
    SID_ACK,
    SID_HDR,
    SID_QUAD,
    SID_INV
  } sid_state_t;

  logic [QUAD_W-1:0] sid_mem [SID_DEPTH];
  sid_state_t        state_q;
  sid_state_t        state_d;
  logic [SID_AW-1:0] wr_ptr_q;
  logic [SID_AW-1:0] rd_ptr_q;
  logic              err_q;
  logic              route_q;
  logic              full_q;

  wire logic              store;
  wire logic              last_rd;
  wire logic [ACK_W-1:0]  ack_code;
  wire logic [QUAD_W-1:0] ack_quad;
  wire logic [QUAD_W-1:0] rd_quad;
  wire logic              emit;
  wire logic [QUAD_W-1:0] emit_data;

  assign store       = (state_q == SID_COLLECT) && selfid_quad_valid && !full_q;
  assign last_rd     = (rd_ptr_q + SID_ONE) == wr_ptr_q;
  assign ack_code    = err_q ? ACK_DATA_ERR : ACK_COMPLETE;
  assign ack_quad    = ACK_QUAD_BASE | QUAD_W'(ack_code);
  assign rd_quad     = sid_mem[rd_ptr_q];
  assign selfid_busy = (state_q != SID_IDLE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      SID_IDLE: begin
        if (selfid_start) begin
          state_d = SID_COLLECT;
        end
      end
      SID_COLLECT: begin
        if (selfid_end) begin
          state_d = route_q ? SID_HDR : SID_ACK;
        end
      end
      SID_ACK:  state_d = SID_HDR;
      SID_HDR: begin
        // a full store wraps the write pointer onto the read pointer
        state_d = (wr_ptr_q == rd_ptr_q && !full_q) ? SID_IDLE : SID_QUAD;
      end
      SID_QUAD: state_d = SID_INV;
      SID_INV: begin
        state_d = last_rd ? SID_IDLE : SID_QUAD;
      end
      default:  state_d = SID_IDLE;
    endcase
  end

  assign emit = (state_q == SID_ACK) || (state_q == SID_HDR) ||
                (state_q == SID_QUAD) || (state_q == SID_INV);

  assign emit_data = (state_q == SID_ACK)  ? ack_quad :
                     (state_q == SID_HDR)  ? SELFID_HEADER :
                     (state_q == SID_QUAD) ? rd_quad :
                     ~rd_quad;

  always_ff @(posedge clk_sys) begin
    if (store) begin
      sid_mem[wr_ptr_q] <= selfid_quad;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      state_q  <= SID_IDLE;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      err_q    <= 1'b0;
      route_q  <= 1'b0;
      full_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == SID_IDLE && selfid_start) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        err_q    <= 1'b0;
        full_q   <= 1'b0;
        route_q  <= selfid_route_select;
      end else begin
        if (store) begin
          wr_ptr_q <= wr_ptr_q + SID_ONE;
          full_q   <= (wr_ptr_q == SID_LAST);
        end
        if (state_q == SID_COLLECT && selfid_error) begin
          err_q <= 1'b1;
        end
        if (state_q == SID_INV) begin
          rd_ptr_q <= rd_ptr_q + SID_ONE;
        end
      end
    end
  end

  // ****************************************************
  // fifo write ports
  // ****************************************************
  always_ff @(posedge clk_sys or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      broadcast_write_rx_fifo_wr   <= 1'b0;
      broadcast_write_rx_fifo_data <= '0;
      bulk_async_rx_fifo_wr        <= 1'b0;
      bulk_async_rx_fifo_data      <= '0;
    end else begin
      broadcast_write_rx_fifo_wr   <= emit && route_q;
      broadcast_write_rx_fifo_data <= emit_data;
      bulk_async_rx_fifo_wr        <= emit && !route_q;
      bulk_async_rx_fifo_data      <= emit_data;
    end
  end

endmodule // link_rx_special_packet_format

//--- link_fmt_properties.sv
`timescale 1ns/10ps
module link_fmt_properties
  import link_fmt_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst_n,
  input wire logic              iso_cycle_end,
  input wire logic              cymark_wr,
  input wire logic [QUAD_W-1:0] cymark_data,
  input wire logic              selfid_end,
  input wire logic              selfid_busy,
  input wire logic              broadcast_write_rx_fifo_wr,
  input wire logic [QUAD_W-1:0] broadcast_write_rx_fifo_data,
  input wire logic              bulk_async_rx_fifo_wr,
  input wire logic [QUAD_W-1:0] bulk_async_rx_fifo_data,
  input wire logic              host_tx_valid,
  input wire logic              host_tx_first,
  input wire logic [QUAD_W-1:0] host_tx_data,
  input wire logic              host_tx_ready,
  input wire logic              phy_tx_valid,
  input wire logic              phy_tx_first,
  input wire logic [QUAD_W-1:0] phy_tx_data,
  input wire logic              phy_tx_ready
);
  wire logic tx_take = host_tx_valid && host_tx_ready;
  wire logic cfg_take = tx_take && host_tx_first && host_tx_data[7:4] == 4'he;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  mark_pulse_a: assert property (iso_cycle_end |=> cymark_wr && cymark_data == 32'h0000_0001)
    else $error("marker not written");
  mark_cause_a: assert property (cymark_wr |-> $past(iso_cycle_end))
    else $error("marker without cycle end");
  tx_retag_a: assert property (cfg_take |=> phy_tx_valid && phy_tx_first &&
    phy_tx_data == {$past(host_tx_data[31:8]), 4'h0, $past(host_tx_data[3:0])})
    else $error("config tcode not replaced");
  tx_pass_a: assert property (tx_take && !cfg_take |=> phy_tx_data == $past(host_tx_data))
    else $error("quadlet altered");
  tx_hold_a: assert property (phy_tx_valid && !phy_tx_ready |=> phy_tx_valid && $stable(phy_tx_data))
    else $error("phy quadlet dropped");
  fifo_excl_a: assert property (!(broadcast_write_rx_fifo_wr && bulk_async_rx_fifo_wr))
    else $error("both fifos written");
  sid_latency_a: assert property (selfid_end && selfid_busy |->
    ##2 (broadcast_write_rx_fifo_wr || bulk_async_rx_fifo_wr)) else $error("self-id late");
  bulk_order_a: assert property ($rose(bulk_async_rx_fifo_wr) |->
    bulk_async_rx_fifo_data[31:4] == 28'h0000_800 ##1 bulk_async_rx_fifo_wr &&
    bulk_async_rx_fifo_data == SELFID_HEADER) else $error("bulk ack or header wrong");
  bcast_head_a: assert property ($rose(broadcast_write_rx_fifo_wr) |->
    broadcast_write_rx_fifo_data == SELFID_HEADER) else $error("broadcast header wrong");
  wr_in_phase_a: assert property (broadcast_write_rx_fifo_wr || bulk_async_rx_fifo_wr |->
    $past(selfid_busy)) else $error("fifo written outside self-id phase");
  tx_stall_a: assert property (phy_tx_valid && !phy_tx_ready |-> !host_tx_ready)
    else $error("host accepted while phy stalls");
  cover property (iso_cycle_end);
  cover property (cfg_take);
  cover property ($rose(broadcast_write_rx_fifo_wr));
  cover property ($rose(bulk_async_rx_fifo_wr));
endmodule // link_fmt_properties
bind link_rx_special_packet_format link_fmt_properties chk (.*);

//--- phy_sink_model.sv
`timescale 1ns/10ps
module phy_sink_model
  import link_fmt_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic              slow,
  input  wire logic              phy_tx_valid,
  input  wire logic              phy_tx_first,
  input  wire logic [QUAD_W-1:0] phy_tx_data,
  output logic                   phy_tx_ready
);
  logic [1:0]    stall_q;
  logic [QUAD_W:0] got[$];
  // slow mode accepts one quadlet in four to hold the link off
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stall_q      <= 2'h0;
      phy_tx_ready <= 1'b1;
    end else begin
      stall_q      <= stall_q + 2'h1;
      phy_tx_ready <= !slow || stall_q == 2'h3;
      if (phy_tx_valid && phy_tx_ready) got.push_back({phy_tx_first, phy_tx_data});
    end
  end
endmodule // phy_sink_model

//--- link_rx_special_packet_format_tb.sv
`timescale 1ns/10ps
module link_rx_special_packet_format_tb;
  import link_fmt_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, slow = 1'b0, iso_cycle_end = 1'b0;
  logic selfid_route_select = 1'b0, selfid_start = 1'b0, selfid_quad_valid = 1'b0;
  logic selfid_end = 1'b0, selfid_error = 1'b0, host_tx_valid = 1'b0, host_tx_first = 1'b0;
  logic [31:0] selfid_quad = 32'h0, host_tx_data = 32'h0, rnd = 32'd95347, r;
  wire  logic cymark_wr, selfid_busy, broadcast_write_rx_fifo_wr, bulk_async_rx_fifo_wr;
  wire  logic host_tx_ready, phy_tx_valid, phy_tx_first, phy_tx_ready;
  wire  logic [31:0] cymark_data, broadcast_write_rx_fifo_data, bulk_async_rx_fifo_data;
  wire  logic [31:0] phy_tx_data;
  int error_cnt = 0, comparisons = 0, cyc = 0, mk = 0, n;
  logic [32:0] eq[$], bq[$], aq[$];
  link_rx_special_packet_format dut (.*);
  phy_sink_model phy (.*);
  always #4 clk_sys = ~clk_sys;
  function automatic logic [31:0] nxt();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  function automatic logic [32:0] exp_tx(input logic first, input logic [31:0] q);
    if (first && q[TCODE_LSB +: TCODE_W] == TCODE_PHYCFG) q[TCODE_LSB +: TCODE_W] = TCODE_PHYOUT;
    return {first, q};
  endfunction
  function automatic logic [32:0] exp_ack(input logic err);
    return {1'b0, ACK_QUAD_BASE | 32'(err ? ACK_DATA_ERR : ACK_COMPLETE)};
  endfunction
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (broadcast_write_rx_fifo_wr) bq.push_back({1'b0, broadcast_write_rx_fifo_data});
    if (bulk_async_rx_fifo_wr) aq.push_back({1'b0, bulk_async_rx_fifo_data});
    if (cymark_wr) begin
      mk++;
      check({1'b0, cymark_data}, 33'h0_0000_0001);
    end
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    n = 0;
    repeat (40) begin
      r = nxt();
      iso_cycle_end <= r[0];
      n += r[0];
      @(posedge clk_sys);
    end
    iso_cycle_end <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(33'(mk), 33'(n));
    $display("cycle mark test done");
    for (int k = 0; k < 24; k++) begin
      r = nxt();
      // flag, root and gap fields stay random: the link must pass them untouched
      r = nxt();
      if (k % 4 < 2) r[7:4] = 4'he;
      slow <= k >= 12;
      host_tx_valid <= 1'b1;
      host_tx_first <= k % 2 == 0;
      host_tx_data  <= r;
      eq.push_back(exp_tx(k % 2 == 0, r));
      do @(posedge clk_sys); while (host_tx_ready !== 1'b1);
    end
    host_tx_valid <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check(33'(phy.got.size()), 33'(eq.size()));
    foreach (eq[i]) check(phy.got[i], eq[i]);
    $display("transmit test done");
    for (int c = 0; c < 8; c++) begin
      eq = {};
      if (!c[0]) eq.push_back(exp_ack(c[1]));
      eq.push_back({1'b0, SELFID_HEADER});
      selfid_route_select <= c[0];
      selfid_start <= 1'b1;
      @(posedge clk_sys);
      selfid_start <= 1'b0;
      selfid_route_select <= !c[0];
      for (int i = 0; i < c[2:1]; i++) begin
        r = nxt();
        eq.push_back({1'b0, r});
        eq.push_back({1'b0, ~r});
        selfid_quad_valid <= 1'b1;
        selfid_quad <= r;
        selfid_error <= c[1] && i == 0;
        @(posedge clk_sys);
      end
      selfid_quad_valid <= 1'b0;
      selfid_error <= 1'b0;
      selfid_end <= 1'b1;
      @(posedge clk_sys);
      selfid_end <= 1'b0;
      do @(posedge clk_sys); while (selfid_busy !== 1'b0);
      repeat (2) @(posedge clk_sys);
      check(33'(c[0] ? aq.size() : bq.size()), 33'h0);
      if (c[0]) aq = bq;
      check(33'(aq.size()), 33'(eq.size()));
      foreach (eq[i]) check(aq[i], eq[i]);
      aq = {};
      bq = {};
    end
    $display("self-id test done");
    print_verdict();
  end
endmodule // link_rx_special_packet_format_tb
